// File: src/msa_regs.sv
`timescale 1ns/1ps

// Overview of operation
// - Writing one to the reduced-interface reset bit resets the RMII module.
// - Speed select one means 100 Mbps, zero means 10 Mbps.
// - 16- and 32-bit accesses work; 8-bit accesses do nothing at all.
// - The width rule applies to set, clear and invert aliases too.
// - Station register bits 15-8 hold the sixth transmitted address octet.
// - Station register bits 7-0 hold the fifth transmitted address octet.
// - Reset loads station register from factory value; software may overwrite.
// - Unimplemented bits read zero and ignore writes.
module msa_regs
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    input wire logic [4:0] bus_addr_i,
    input wire logic [1:0] bus_size_i,
    input wire logic bus_half_i,
    input wire logic [31:0] bus_wdata_i,
    output logic [31:0] bus_rdata_o,
    output logic bus_rvalid_o,
    output logic reduced_if_logic_reset_o,
    output logic reduced_if_speed_select_o,
    output logic rmii_run_10_o,
    output logic rmii_run_100_o,
    output logic [7:0] station_octet_six_o,
    output logic [7:0] station_octet_five_o
);
    import msa_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Decode.

    logic [2:0] idx;
    logic [1:0] alias_sel;
    logic size_ok;
    logic [31:0] be_mask;
    logic [31:0] supp_reg;
    logic [31:0] supp_next;
    logic [31:0] supp_new;
    logic [31:0] sa0_reg;
    logic [31:0] sa0_next;
    logic [31:0] sa0_new;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    msa_state_t state_reg;
    msa_state_t state_next;
    logic run10_reg;
    logic run10_next;
    logic run100_reg;
    logic run100_next;

    assign idx = {2'h0, bus_addr_i[MSA_ADDR_REG_BIT]};
    assign alias_sel = bus_addr_i[MSA_ADDR_ALIAS_HI:MSA_ADDR_ALIAS_LO];
    // Byte accesses are dropped by size_ok after the alias logic has computed its result.
    assign size_ok = (bus_size_i == MSA_SIZE_16) || (bus_size_i == MSA_SIZE_32);

    always_comb
    begin
        if (bus_size_i == MSA_SIZE_32)
        begin
            be_mask = MSA_LANES_ALL;
        end
        else if (bus_half_i)
        begin
            be_mask = MSA_LANES_HIGH;
        end
        else
        begin
            be_mask = MSA_LANES_LOW;
        end
    end

    msa_alias_calc u_calc_supp
    (
        .alias_i(alias_sel),
        .old_i(supp_reg),
        .wdata_i(bus_wdata_i),
        .be_mask_i(be_mask),
        .impl_mask_i(MSA_SUPP_MASK),
        .new_o(supp_new)
    );

    msa_alias_calc u_calc_sa0
    (
        .alias_i(alias_sel),
        .old_i(sa0_reg),
        .wdata_i(bus_wdata_i),
        .be_mask_i(be_mask),
        .impl_mask_i(MSA_SA0_MASK),
        .new_o(sa0_new)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Registers.

    always_comb
    begin
        supp_next = supp_reg;
        sa0_next = sa0_reg;
        rdata_next = rdata_reg;
        rvalid_next = 1'b0;
        // Refused sizes never reach the case below, whichever alias they address.
        if (bus_wr_i && size_ok)
        begin
            case (idx)
                MSA_IDX_SUPP:
                begin
                    supp_next = supp_new;
                end
                MSA_IDX_SA0:
                begin
                    sa0_next = sa0_new;
                end
                default:
                begin
                    supp_next = supp_reg;
                end
            endcase
        end
        if (bus_rd_i && size_ok)
        begin
            rvalid_next = 1'b1;
            // A write in the same cycle lands afterwards, so the read returns the old value.
            case (idx)
                MSA_IDX_SUPP:
                begin
                    rdata_next = supp_reg & MSA_SUPP_MASK & be_mask;
                end
                MSA_IDX_SA0:
                begin
                    rdata_next = sa0_reg & MSA_SA0_MASK & be_mask;
                end
                default:
                begin
                    // Index values without a register read as zero.
                    rdata_next = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            supp_reg <= MSA_SUPP_RESET;
            sa0_reg <= {16'h0000, MSA_FACTORY_SA0};
            rdata_reg <= 32'h0000_0000;
            rvalid_reg <= 1'b0;
        end
        else if (clk_en_i)
        begin
            supp_reg <= supp_next;
            sa0_reg <= sa0_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // RMII run state. One cycle behind the register, so outputs stay registered.

    always_comb
    begin
        case (state_reg)
            MSA_ST_HELD,
            MSA_ST_RUN10,
            MSA_ST_RUN100:
            begin
                if (supp_reg[MSA_BIT_RESET])
                begin
                    state_next = MSA_ST_HELD;
                end
                else if (supp_reg[MSA_BIT_SPEED])
                begin
                    state_next = MSA_ST_RUN100;
                end
                else
                begin
                    state_next = MSA_ST_RUN10;
                end
            end
            default: state_next = MSA_ST_HELD;
        endcase
        // Decoded here so that the run outputs leave straight from flip-flops.
        run10_next = (state_next == MSA_ST_RUN10);
        run100_next = (state_next == MSA_ST_RUN100);
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            state_reg <= MSA_ST_HELD;
            run10_reg <= 1'b0;
            run100_reg <= 1'b0;
        end
        else if (clk_en_i)
        begin
            state_reg <= state_next;
            run10_reg <= run10_next;
            run100_reg <= run100_next;
        end
    end

    assign bus_rdata_o = rdata_reg;
    assign bus_rvalid_o = rvalid_reg;
    assign reduced_if_logic_reset_o = supp_reg[MSA_BIT_RESET];
    assign reduced_if_speed_select_o = supp_reg[MSA_BIT_SPEED];
    assign rmii_run_10_o = run10_reg;
    assign rmii_run_100_o = run100_reg;
    assign station_octet_six_o = sa0_reg[MSA_OCT6_HI:MSA_OCT6_LO];
    assign station_octet_five_o = sa0_reg[MSA_OCT5_HI:MSA_OCT5_LO];

endmodule : msa_regs

// File: src/msa_pkg.sv
package msa_pkg;

    // Register word indices within the block's address window.
    localparam logic [2:0] MSA_IDX_SUPP = 3'h0;
    localparam logic [2:0] MSA_IDX_SA0 = 3'h1;

    // Alias selector, kept in address bits [3:2] of each register's block.
    localparam logic [1:0] MSA_ALIAS_PLAIN = 2'h0;
    localparam logic [1:0] MSA_BIT_CLEAR_ALIAS = 2'h1;
    localparam logic [1:0] MSA_ALIAS_SET = 2'h2;
    localparam logic [1:0] MSA_BIT_INVERT_ALIAS = 2'h3;

    // Byte address fields: register select bit and alias selector bits.
    localparam int MSA_ADDR_REG_BIT = 4;
    localparam int MSA_ADDR_ALIAS_HI = 3;
    localparam int MSA_ADDR_ALIAS_LO = 2;

    // Station register octet positions.
    localparam int MSA_OCT6_HI = 15;
    localparam int MSA_OCT6_LO = 8;
    localparam int MSA_OCT5_HI = 7;
    localparam int MSA_OCT5_LO = 0;

    // Byte-lane masks for a full word and for the two halves of a 16-bit access.
    localparam logic [31:0] MSA_LANES_ALL = 32'hffff_ffff;
    localparam logic [31:0] MSA_LANES_HIGH = 32'hffff_0000;
    localparam logic [31:0] MSA_LANES_LOW = 32'h0000_ffff;

    // Access size codes.
    localparam logic [1:0] MSA_SIZE_8 = 2'h0;
    localparam logic [1:0] MSA_SIZE_16 = 2'h1;
    localparam logic [1:0] MSA_SIZE_32 = 2'h2;

    // Field positions.
    localparam int MSA_BIT_RESET = 11;
    localparam int MSA_BIT_SPEED = 8;
    localparam logic [31:0] MSA_SUPP_MASK = 32'h0000_0900;
    localparam logic [31:0] MSA_SA0_MASK = 32'h0000_ffff;
    localparam logic [31:0] MSA_SUPP_RESET = 32'h0000_0000;

    // Factory station octets; value is arbitrary.
    localparam logic [15:0] MSA_FACTORY_SA0 = 16'h5a3c;

    typedef enum logic [2:0] {
        MSA_ST_HELD = 3'b001,
        MSA_ST_RUN10 = 3'b010,
        MSA_ST_RUN100 = 3'b100
    } msa_state_t;

endpackage : msa_pkg

// File: src/msa_alias_calc.sv
`timescale 1ns/1ps

// Computes the new register value for a plain, set, clear or invert write.
module msa_alias_calc
(
    input wire logic [1:0] alias_i,
    input wire logic [31:0] old_i,
    input wire logic [31:0] wdata_i,
    input wire logic [31:0] be_mask_i,
    input wire logic [31:0] impl_mask_i,
    output logic [31:0] new_o
);
    import msa_pkg::*;

    logic [31:0] raw;

    always_comb
    begin
        case (alias_i)
            MSA_BIT_CLEAR_ALIAS: raw = old_i & ~wdata_i;
            MSA_ALIAS_SET: raw = old_i | wdata_i;
            MSA_BIT_INVERT_ALIAS: raw = old_i ^ wdata_i;
            default: raw = wdata_i;
        endcase
        // Only enabled lanes of implemented bits change; other lanes keep old value, unimplemented bits clear.
        new_o = ((raw & be_mask_i) | (old_i & ~be_mask_i)) & impl_mask_i;
    end

endmodule : msa_alias_calc

// File: verification/msa_checker.sv
`timescale 1ns/1ps

module msa_checker
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    input wire logic [4:0] bus_addr_i,
    input wire logic [1:0] bus_size_i,
    input wire logic bus_half_i,
    input wire logic [31:0] bus_wdata_i,
    input wire logic [31:0] bus_rdata_o,
    input wire logic bus_rvalid_o,
    input wire logic reduced_if_logic_reset_o,
    input wire logic reduced_if_speed_select_o,
    input wire logic rmii_run_10_o,
    input wire logic rmii_run_100_o,
    input wire logic [7:0] station_octet_six_o,
    input wire logic [7:0] station_octet_five_o
);
    logic live;
    logic size_ok;
    logic ok;
    logic rdok;
    logic [17:0] regs;
    // An edge at which the synchronous reset is applied takes no access.
    assign live = rst_n_i && clk_en_i;
    assign size_ok = bus_size_i == 2'h1 || bus_size_i == 2'h2;
    assign ok = live && size_ok;
    // The upper half of a 16-bit read only reaches unimplemented bits.
    assign rdok = bus_rd_i && ok && !(bus_size_i == 2'h1 && bus_half_i);
    assign regs = {reduced_if_logic_reset_o, reduced_if_speed_select_o, station_octet_six_o, station_octet_five_o};
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    property p_ack;
        bus_rd_i && ok |=> bus_rvalid_o;
    endproperty
    a_ack: assert property (p_ack) else $error("read not answered");
    property p_narrow;
        live && (bus_wr_i || bus_rd_i) && !size_ok |=> $stable(regs) && !bus_rvalid_o;
    endproperty
    a_narrow: assert property (p_narrow) else $error("narrow access acted");
    property p_frozen;
        rst_n_i && !clk_en_i |=> $stable(regs) && $stable(bus_rvalid_o) && $stable(bus_rdata_o)
            && $stable({rmii_run_10_o, rmii_run_100_o});
    endproperty
    a_frozen: assert property (p_frozen) else $error("state moved while disabled");
    property p_sa_rd;
        rdok && bus_addr_i[4] |=> bus_rdata_o == {16'h0000, $past(regs[15:0])};
    endproperty
    a_sa_rd: assert property (p_sa_rd) else $error("station read");
    property p_sp_rd;
        rdok && !bus_addr_i[4] |=> bus_rdata_o == {20'h0, $past(regs[17]), 2'h0, $past(regs[16]), 8'h00};
    endproperty
    a_sp_rd: assert property (p_sp_rd) else $error("support read");
    property p_held;
        live && reduced_if_logic_reset_o |=> !rmii_run_10_o && !rmii_run_100_o;
    endproperty
    a_held: assert property (p_held) else $error("not held");
    property p_run;
        live && !reduced_if_logic_reset_o |=> rmii_run_100_o == $past(regs[16]) && rmii_run_10_o != rmii_run_100_o;
    endproperty
    a_run: assert property (p_run) else $error("wrong speed");
    property p_rst;
        $rose(rst_n_i) |-> regs == {2'b00, msa_pkg::MSA_FACTORY_SA0};
    endproperty
    a_rst: assert property (p_rst) else $error("reset value");
    property p_wr;
        bus_wr_i && live && bus_size_i == 2'h2 && bus_addr_i[4:2] == 3'h4 |=> regs[15:0] == $past(bus_wdata_i[15:0]);
    endproperty
    a_wr: assert property (p_wr) else $error("station write");
endmodule : msa_checker

bind msa_regs msa_checker u_chk (.*);

// File: verification/tb.sv
`timescale 1ns/1ps

module tb;
    import msa_pkg::*;
    logic sys_clk_i = 0, rst_n_i = 0, clk_en_i = 1, bus_wr_i = 0, bus_rd_i = 0, bus_half_i = 0;
    logic [4:0] bus_addr_i = 0;
    logic [1:0] bus_size_i = 0;
    logic [31:0] bus_wdata_i = 0, bus_rdata_o;
    logic bus_rvalid_o, reduced_if_logic_reset_o, reduced_if_speed_select_o, rmii_run_10_o, rmii_run_100_o;
    logic [7:0] station_octet_six_o, station_octet_five_o;
    int error_cnt = 0, check_count = 0;
    msa_regs u_dut (.*);
    initial
    begin
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    task stop_test;
        if (error_cnt == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test
    task chk(input logic [32:0] s, input logic [32:0] e);
        check_count++;
        if (s !== e)
        begin
            error_cnt++;
            $display("wrong value at %0t: %h, expected %h", $time, s, e);
        end
    endtask : chk
    // Holds the strobe for exactly one clock edge, then returns at the next falling edge.
    task acc(input logic w, input logic [4:0] a, input logic [1:0] s, input logic h, input logic [31:0] d);
        @(posedge sys_clk_i);
        bus_wr_i <= w;
        bus_rd_i <= !w;
        bus_addr_i <= a;
        bus_size_i <= s;
        bus_half_i <= h;
        bus_wdata_i <= d;
        @(posedge sys_clk_i);
        bus_wr_i <= 0;
        bus_rd_i <= 0;
        @(negedge sys_clk_i);
    endtask : acc
    task rd(input logic [4:0] a, input logic [1:0] s, input logic h, input logic [31:0] e);
        acc(0, a, s, h, 0);
        chk({bus_rvalid_o, bus_rdata_o}, {1'b1, e});
    endtask : rd
    initial
    begin
        repeat (12) @(posedge sys_clk_i);
        rst_n_i <= 1;
        rd(5'h00, 2'h2, 0, 0);
        rd(5'h10, 2'h1, 0, {16'h0, MSA_FACTORY_SA0});
        acc(1, 5'h00, 2'h2, 0, '1);
        @(negedge sys_clk_i);
        chk({reduced_if_logic_reset_o, rmii_run_10_o, rmii_run_100_o}, 3'b100);
        rd(5'h00, 2'h2, 0, 32'h900);
        acc(1, 5'h04, 2'h1, 0, 32'h800);
        @(negedge sys_clk_i);
        chk({reduced_if_speed_select_o, rmii_run_10_o, rmii_run_100_o}, 3'b101);
        acc(1, 5'h0c, 2'h2, 0, 32'h100);
        @(negedge sys_clk_i);
        chk({reduced_if_speed_select_o, rmii_run_10_o, rmii_run_100_o}, 3'b010);
        acc(1, 5'h08, 2'h0, 0, 32'h900);
        acc(1, 5'h18, 2'h3, 0, 32'hffff);
        acc(0, 5'h00, 2'h0, 0, 0);
        chk(bus_rvalid_o, 0);
        rd(5'h00, 2'h2, 0, 0);
        rd(5'h10, 2'h2, 0, {16'h0, MSA_FACTORY_SA0});
        // The set alias with a 16-bit access must act like a full-width one.
        acc(1, 5'h08, 2'h1, 0, 32'h900);
        rd(5'h00, 2'h1, 0, 32'h900);
        acc(1, 5'h10, 2'h2, 0, 32'h1234abcd);
        chk({station_octet_six_o, station_octet_five_o}, 16'habcd);
        acc(1, 5'h18, 2'h1, 1, 32'hffff0000);
        @(posedge sys_clk_i);
        clk_en_i <= 0;
        acc(1, 5'h10, 2'h2, 0, 0);
        @(posedge sys_clk_i);
        clk_en_i <= 1;
        rd(5'h10, 2'h2, 0, 32'habcd);
        rd(5'h10, 2'h1, 1, 0);
        // A second reset in mid-run must reload the station value and clear the reset bit and both run outputs.
        @(posedge sys_clk_i);
        rst_n_i <= 0;
        repeat (2) @(posedge sys_clk_i);
        rst_n_i <= 1;
        @(negedge sys_clk_i);
        chk({reduced_if_logic_reset_o, rmii_run_10_o, rmii_run_100_o}, 3'b000);
        rd(5'h10, 2'h2, 0, {16'h0, MSA_FACTORY_SA0});
        stop_test;
    end
    initial
    begin
        #20us;
        error_cnt++;
        stop_test;
    end
endmodule : tb
